// *** uhp_regs.svh ***
// register offsets, field positions and reset values of the pm/extension bank
`ifndef UHP_REGS_SVH
`define UHP_REGS_SVH

// ****************************************
// configuration dword offsets
// ****************************************
`define UHP_OFS_PMC 8'h40
`define UHP_OFS_PWR_CS 8'h44
`define UHP_OFS_EXT_ONE 8'hE0

// ****************************************
// power-management control/status fields
// ****************************************
`define UHP_PS_LSB 0
`define UHP_PS_MSB 1
`define UHP_EVT_EN_BIT 8
`define UHP_EVT_FLAG_BIT 15
`define UHP_PWR_CS_WR_MASK 16'h0103
`define UHP_PWR_CS_RST 16'h0000

// ****************************************
// power-management capability fields
// ****************************************
`define UHP_PMC_FIXED 16'h7E02
`define UHP_PMC_AUX_LSB 6
`define UHP_PMC_AUX_MSB 8
`define UHP_PMC_D3C_BIT 15
`define UHP_PMC_HALF_LSB 16
`define UHP_AUX_RST 3'h0

// ****************************************
// extension register fields
// ****************************************
`define UHP_EXT_ONE_RST 32'h6CB0_3305
`define UHP_EXT_ONE_WR_MASK 32'hFF7F_FFFF
`define UHP_EXT_ONE_FIXED1 32'h0080_0000
`define UHP_FIXED1_BIT 23
`define UHP_PORTN_MSB 2
`define UHP_LEGC_BIT 3
`define UHP_UNLOCK_BIT 7
`define UHP_PPC_BIT 21
`define UHP_PORTN_5 3'h5
`define UHP_PORTN_4 3'h4
`define UHP_PORTN_3 3'h3
`define UHP_PORTN_2 3'h2
`define UHP_PORTS_5 5'h1F
`define UHP_PORTS_4 5'h0F
`define UHP_PORTS_3 5'h07
`define UHP_PORTS_2 5'h03
`define UHP_PORTS_0 5'h00

`endif

// *** uhp_pkg.sv ***
// types shared by the pm/extension bank
package uhp_pkg;
  // power states in their register encoding order
  typedef enum logic [1:0] {
    UHP_D0,
    UHP_D1,
    UHP_D2,
    UHP_D3HOT
  } uhp_pstate_type;
endpackage

// *** uhp_pm_if.sv ***
// carrier between the config decoder and the power-event unit
`timescale 1ns/1ps
interface uhp_pm_if;
  logic wr;
  logic [15:0] wdata;
  logic [1:0] be;
  logic d3cold_sup;
  logic [15:0] rd_val;
  modport ctrl (output wr, output wdata, output be, output d3cold_sup, input rd_val);
  modport pm (input wr, input wdata, input be, input d3cold_sup, output rd_val);
endinterface

// *** uhp_pm_event.sv ***
// power state, event enable and sticky event flag
`timescale 1ns/1ps
`include "uhp_regs.svh"
module uhp_pm_event
  import uhp_pkg::*;
(
  // clock and resets
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic auxrstn_in,
  // register access
  uhp_pm_if.pm pm,
  // core side
  input wire logic resume_detected_in,
  output uhp_pstate_type pstate_out,
  output logic power_event_out
);

  uhp_pstate_type pstate_reg;
  logic power_event_enable_reg;
  logic power_event_flag_reg;
  logic resume_seen_reg;
  logic resume_rise;

  // power state is plain config state, reset to d0
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pstate_reg <= UHP_D0;
    end else if (pm.wr && pm.be[0]) begin
      pstate_reg <= uhp_pstate_type'(pm.wdata[`UHP_PS_MSB:`UHP_PS_LSB]);
    end
  end

  // edge of the resume status so a held level sets the flag only once
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      resume_seen_reg <= 1'b0;
    end else begin
      resume_seen_reg <= resume_detected_in;
    end
  end
  assign resume_rise = resume_detected_in && !resume_seen_reg;

  // enable: kept over function reset only when d3cold events are supported
  always_ff @(posedge clk_in or negedge auxrstn_in) begin
    if (!auxrstn_in) begin
      power_event_enable_reg <= 1'b0;
    end else if (!rstn_in && !pm.d3cold_sup) begin
      power_event_enable_reg <= 1'b0;
    end else if (pm.wr && pm.be[1]) begin
      power_event_enable_reg <= pm.wdata[`UHP_EVT_EN_BIT];
    end
  end

  // flag: set by resume regardless of enable; set beats write-one clear
  always_ff @(posedge clk_in or negedge auxrstn_in) begin
    if (!auxrstn_in) begin
      power_event_flag_reg <= 1'b0;
    end else if (!rstn_in && !pm.d3cold_sup) begin
      power_event_flag_reg <= 1'b0;
    end else if (resume_rise) begin
      power_event_flag_reg <= 1'b1;
    end else if (pm.wr && pm.be[1] && pm.wdata[`UHP_EVT_FLAG_BIT]) begin
      power_event_flag_reg <= 1'b0;
    end
  end

  // event pin from flops only, so it works in every d-state
  assign power_event_out = power_event_enable_reg && power_event_flag_reg;
  assign pstate_out = pstate_reg;

  // data select/scale and reserved bits read zero
  always_comb begin
    pm.rd_val = `UHP_PWR_CS_RST;
    pm.rd_val[`UHP_PS_MSB:`UHP_PS_LSB] = pstate_reg;
    pm.rd_val[`UHP_EVT_EN_BIT] = power_event_enable_reg;
    pm.rd_val[`UHP_EVT_FLAG_BIT] = power_event_flag_reg;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_resume_sets_flag;
    @(posedge clk_in) disable iff (!rstn_in || !auxrstn_in)
      resume_rise |=> power_event_flag_reg;
  endproperty
  a_resume_sets_flag: assert property (p_resume_sets_flag) else $error("flag not set");

  property p_w1c_clears;
    @(posedge clk_in) disable iff (!rstn_in || !auxrstn_in)
      (pm.wr && pm.be[1] && pm.wdata[`UHP_EVT_FLAG_BIT] && !resume_rise) |=> !power_event_flag_reg;
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("flag not cleared");

  // a resume in the same cycle may set the flag, so it is left out here
  property p_w0_keeps;
    @(posedge clk_in) disable iff (!rstn_in || !auxrstn_in)
      (pm.wr && !pm.wdata[`UHP_EVT_FLAG_BIT] && !resume_rise) |=> $stable(power_event_flag_reg);
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("flag changed by zero");

  property p_enable_gates;
    @(posedge clk_in) disable iff (!rstn_in || !auxrstn_in)
      (pm.wr && pm.be[1] && !pm.wdata[`UHP_EVT_EN_BIT]) |=> !power_event_out;
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("event while disabled");

  property p_pstate_written;
    @(posedge clk_in) disable iff (!rstn_in)
      (pm.wr && pm.be[0]) |=> pstate_reg == $past(pm.wdata[`UHP_PS_MSB:`UHP_PS_LSB]);
  endproperty
  a_pstate_written: assert property (p_pstate_written) else $error("state not taken");
endmodule

// *** uhp_cfg_bank.sv ***
// pm control/status and extension configuration bank of one usb host core
`timescale 1ns/1ps
`include "uhp_regs.svh"
module uhp_cfg_bank
  import uhp_pkg::*;
(
  // clock and resets
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic auxrstn_in,
  // configuration access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  output logic cfg_retry_out,
  // serial rom preload
  input wire logic rom_busy_in,
  input wire logic rom_ext_wr_in,
  input wire logic [31:0] rom_ext_in,
  input wire logic rom_cap_wr_in,
  input wire logic [3:0] rom_cap_in,
  // core and pins
  input wire logic resume_detected_in,
  input wire logic legacy_strap_in,
  output logic power_event_out,
  output logic suspend_out,
  output logic core_clk_en_out,
  output logic [1:0] power_state_out,
  output logic [4:0] port_enable_out,
  output logic legacy_io_space_out,
  output logic legacy_direct_out,
  output logic subsys_id_write_unlock_out,
  output logic port_power_switch_report_out
);

  uhp_pm_if pm_bus ();
  uhp_pstate_type pstate;
  logic [31:0] extension_config_one_reg;
  logic [2:0] aux_current_reg;
  logic d3cold_sup_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic take;
  logic wr_take;
  logic [31:0] be_mask;
  logic unlock;
  logic [15:0] pmc_hi;

  // expand byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // keep bits outside the mask, take new ones inside
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ****************************************
  // access acceptance
  // ****************************************
  // no access is taken while the rom preload runs; requester must retry
  assign take = (cfg_wr_in || cfg_rd_in) && !rom_busy_in;
  assign wr_take = cfg_wr_in && !rom_busy_in;
  assign cfg_retry_out = (cfg_wr_in || cfg_rd_in) && rom_busy_in;
  assign be_mask = lane_mask(cfg_be_in);
  assign unlock = extension_config_one_reg[`UHP_UNLOCK_BIT];

  // ****************************************
  // extension register
  // ****************************************
  // private fields are stored as written; keeping them legal is software's job
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      extension_config_one_reg <= `UHP_EXT_ONE_RST;
    end else if (rom_ext_wr_in) begin
      // rom image never touches the unlock bit
      extension_config_one_reg <= merge(extension_config_one_reg, rom_ext_in,
                                        `UHP_EXT_ONE_WR_MASK & ~(32'h0000_0001 << `UHP_UNLOCK_BIT));
    end else if (wr_take && cfg_addr_in == `UHP_OFS_EXT_ONE) begin
      extension_config_one_reg <= merge(extension_config_one_reg, cfg_wdata_in,
                                        be_mask & `UHP_EXT_ONE_WR_MASK);
    end
  end

  // ****************************************
  // conditionally writable capability fields
  // ****************************************
  // aux current and d3cold support survive function reset, as the rom set them
  always_ff @(posedge clk_in or negedge auxrstn_in) begin
    if (!auxrstn_in) begin
      aux_current_reg <= `UHP_AUX_RST;
      d3cold_sup_reg <= 1'b0;
    end else if (rom_cap_wr_in) begin
      aux_current_reg <= rom_cap_in[2:0];
      d3cold_sup_reg <= rom_cap_in[3];
    end else if (wr_take && cfg_addr_in == `UHP_OFS_PMC && unlock) begin
      if (cfg_be_in[2] && cfg_be_in[3]) begin
        aux_current_reg <= cfg_wdata_in[`UHP_PMC_HALF_LSB + `UHP_PMC_AUX_MSB:
                                        `UHP_PMC_HALF_LSB + `UHP_PMC_AUX_LSB];
      end
      if (cfg_be_in[3]) begin
        d3cold_sup_reg <= cfg_wdata_in[`UHP_PMC_HALF_LSB + `UHP_PMC_D3C_BIT];
      end
    end
  end

  // ****************************************
  // power-event unit
  // ****************************************
  assign pm_bus.wr = wr_take && cfg_addr_in == `UHP_OFS_PWR_CS;
  assign pm_bus.wdata = cfg_wdata_in[15:0];
  assign pm_bus.be = cfg_be_in[1:0];
  assign pm_bus.d3cold_sup = d3cold_sup_reg;

  uhp_pm_event uhp_pm_event_inst (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .auxrstn_in(auxrstn_in),
    .pm(pm_bus),
    .resume_detected_in(resume_detected_in),
    .pstate_out(pstate),
    .power_event_out(power_event_out)
  );

  // ****************************************
  // read path
  // ****************************************
  // capability upper half: fixed bits with the loaded fields laid over them
  always_comb begin
    pmc_hi = `UHP_PMC_FIXED;
    pmc_hi[`UHP_PMC_AUX_MSB:`UHP_PMC_AUX_LSB] = aux_current_reg;
    pmc_hi[`UHP_PMC_D3C_BIT] = d3cold_sup_reg;
  end

  // answer registered one cycle after the access is taken
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= take;
      if (take && cfg_rd_in) begin
        case (cfg_addr_in)
          `UHP_OFS_PMC: rdata_reg <= {pmc_hi, 16'h0000};
          `UHP_OFS_PWR_CS: rdata_reg <= {16'h0000, pm_bus.rd_val};
          `UHP_OFS_EXT_ONE: rdata_reg <= extension_config_one_reg | `UHP_EXT_ONE_FIXED1;
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign cfg_rdata_out = rdata_reg;
  assign cfg_ack_out = ack_reg;

  // ****************************************
  // decoded controls
  // ****************************************
  // any non-d0 state is global suspend with the core clock stopped
  assign suspend_out = pstate != UHP_D0;
  assign core_clk_en_out = pstate == UHP_D0;
  assign power_state_out = pstate;
  assign subsys_id_write_unlock_out = unlock;
  assign port_power_switch_report_out = extension_config_one_reg[`UHP_PPC_BIT];
  // low strap forces direct interception regardless of the mode bit
  assign legacy_io_space_out = extension_config_one_reg[`UHP_LEGC_BIT] && legacy_strap_in;
  assign legacy_direct_out = !legacy_io_space_out;

  // prohibited counts enable no port rather than guessing
  always_comb begin
    case (extension_config_one_reg[`UHP_PORTN_MSB:0])
      `UHP_PORTN_5: port_enable_out = `UHP_PORTS_5;
      `UHP_PORTN_4: port_enable_out = `UHP_PORTS_4;
      `UHP_PORTN_3: port_enable_out = `UHP_PORTS_3;
      `UHP_PORTN_2: port_enable_out = `UHP_PORTS_2;
      default: port_enable_out = `UHP_PORTS_0;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  property p_suspend_state;
    @(posedge clk_in) disable iff (!rstn_in)
      suspend_out == (power_state_out != UHP_D0) && core_clk_en_out == !suspend_out;
  endproperty
  a_suspend_state: assert property (p_suspend_state) else $error("suspend mismatch");

  property p_strap_low;
    @(posedge clk_in) disable iff (!rstn_in)
      !legacy_strap_in |-> legacy_direct_out && !legacy_io_space_out;
  endproperty
  a_strap_low: assert property (p_strap_low) else $error("strap ignored");

  property p_locked_cap;
    @(posedge clk_in) disable iff (!rstn_in || !auxrstn_in)
      (wr_take && cfg_addr_in == `UHP_OFS_PMC && !unlock && !rom_cap_wr_in)
        |=> $stable(aux_current_reg) && $stable(d3cold_sup_reg);
  endproperty
  a_locked_cap: assert property (p_locked_cap) else $error("locked field written");

  property p_no_take_busy;
    @(posedge clk_in) disable iff (!rstn_in)
      rom_busy_in |=> !cfg_ack_out;
  endproperty
  a_no_take_busy: assert property (p_no_take_busy) else $error("access during rom load");

  property p_ext_bit23;
    @(posedge clk_in) disable iff (!rstn_in)
      (cfg_rd_in && !rom_busy_in && cfg_addr_in == `UHP_OFS_EXT_ONE)
        |=> cfg_rdata_out[`UHP_FIXED1_BIT];
  endproperty
  a_ext_bit23: assert property (p_ext_bit23) else $error("bit 23 not one");

  property p_ppc_follows;
    @(posedge clk_in) disable iff (!rstn_in)
      (wr_take && cfg_addr_in == `UHP_OFS_EXT_ONE && cfg_be_in[2] && !rom_ext_wr_in)
        |=> port_power_switch_report_out == $past(cfg_wdata_in[`UHP_PPC_BIT]);
  endproperty
  a_ppc_follows: assert property (p_ppc_follows) else $error("report not updated");
endmodule

// *** uhp_rom_model.sv ***
// serial rom preload model for the pm/extension bank
`timescale 1ns/1ps
module uhp_rom_model (
  // clock and start
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [31:0] image_in,
  input wire logic [3:0] cap_in,
  // rom port
  output logic busy_out,
  output logic ext_wr_out,
  output logic [31:0] ext_out,
  output logic cap_wr_out,
  output logic [3:0] cap_out
);
  initial begin
    busy_out = 1'b0;
    ext_wr_out = 1'b0;
    ext_out = 32'h0000_0000;
    cap_wr_out = 1'b0;
    cap_out = 4'h0;
  end
  // busy spans the whole slow fetch so no config access slips in first
  always @(posedge start_in) begin
    @(posedge clk_in);
    busy_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    ext_out <= image_in;
    ext_wr_out <= 1'b1;
    @(posedge clk_in);
    ext_wr_out <= 1'b0;
    ext_out <= ~image_in;  // stale data lines never show the last image
    cap_out <= cap_in;
    cap_wr_out <= 1'b1;
    @(posedge clk_in);
    cap_wr_out <= 1'b0;
    cap_out <= ~cap_in;
    @(posedge clk_in);
    busy_out <= 1'b0;
  end
endmodule

// *** uhp_cfg_bank_test.sv ***
// self-checking bench for the pm/extension configuration bank
`timescale 1ns/1ps
`include "uhp_regs.svh"
module uhp_cfg_bank_test;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic auxrstn_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic cfg_rd_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [3:0] cfg_be_in = 4'h0;
  logic [31:0] cfg_wdata_in = 32'h0000_0000;
  logic resume_detected_in = 1'b0;
  logic legacy_strap_in = 1'b0;
  logic rom_start = 1'b0;
  wire logic [31:0] cfg_rdata_out, rom_ext;
  wire logic cfg_ack_out, cfg_retry_out, rom_busy, rom_ext_wr, rom_cap_wr;
  wire logic [3:0] rom_cap;
  wire logic power_event_out, suspend_out, core_clk_en_out, legacy_io_space_out;
  wire logic legacy_direct_out, subsys_id_write_unlock_out, port_power_switch_report_out;
  wire logic [1:0] power_state_out;
  wire logic [4:0] port_enable_out;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  uhp_cfg_bank uhp_cfg_bank_inst (.clk_in(clk_in), .rstn_in(rstn_in), .auxrstn_in(auxrstn_in),
    .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in),
    .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_ack_out(cfg_ack_out), .cfg_retry_out(cfg_retry_out), .rom_busy_in(rom_busy),
    .rom_ext_wr_in(rom_ext_wr), .rom_ext_in(rom_ext), .rom_cap_wr_in(rom_cap_wr),
    .rom_cap_in(rom_cap), .resume_detected_in(resume_detected_in),
    .legacy_strap_in(legacy_strap_in), .power_event_out(power_event_out),
    .suspend_out(suspend_out), .core_clk_en_out(core_clk_en_out),
    .power_state_out(power_state_out), .port_enable_out(port_enable_out),
    .legacy_io_space_out(legacy_io_space_out), .legacy_direct_out(legacy_direct_out),
    .subsys_id_write_unlock_out(subsys_id_write_unlock_out),
    .port_power_switch_report_out(port_power_switch_report_out));

  uhp_rom_model uhp_rom_model_inst (.clk_in(clk_in), .start_in(rom_start),
    .image_in(32'h6C90_3303), .cap_in(4'h8), .busy_out(rom_busy),
    .ext_wr_out(rom_ext_wr), .ext_out(rom_ext), .cap_wr_out(rom_cap_wr),
    .cap_out(rom_cap));

  initial begin
    forever #50 clk_in = ~clk_in;
  end
  // hang guard, well above the roughly 130 cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("timeout");
      results();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; ack is checked half a cycle after the taking edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge clk_in);
    cfg_wr_in = wr;
    cfg_rd_in = !wr;
    cfg_addr_in = a;
    cfg_be_in = 4'hF;
    cfg_wdata_in = d;
    @(negedge clk_in);
    cfg_wr_in = 1'b0;
    cfg_rd_in = 1'b0;
    cfg_wdata_in = ~d;
    chk(cfg_ack_out, 32'h1);
    q = cfg_rdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic resume_pulse;
    @(negedge clk_in);
    resume_detected_in = 1'b1;
    @(negedge clk_in);
    resume_detected_in = 1'b0;
  endtask
  // several edges low so the non-sticky clear gets its clock
  task automatic func_reset;
    @(negedge clk_in);
    rstn_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rstn_in = 1'b1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdc(`UHP_OFS_EXT_ONE, 32'h6CB0_3305);
    rdc(`UHP_OFS_PWR_CS, 32'h0000_0000);
    rdc(`UHP_OFS_PMC, 32'h7E02_0000);
    rdc(8'h80, 32'h0000_0000);
    chk(port_enable_out, 32'h1F);
    chk(port_power_switch_report_out, 32'h1);
    chk(subsys_id_write_unlock_out, 32'h0);
    $display("test reset done");
  endtask
  // read-only bits are written as ones alongside every state
  task automatic t_pstate;
    for (int s = 3; s >= 0; s--) begin
      wr(`UHP_OFS_PWR_CS, 32'h0000_7EFC | s);
      rdc(`UHP_OFS_PWR_CS, s);
      chk(power_state_out, s);
      chk(suspend_out, s != 0);
      chk(core_clk_en_out, s == 0);
    end
    $display("test power state done");
  endtask
  task automatic t_event;
    wr(`UHP_OFS_PWR_CS, 32'h0000_0003);
    resume_pulse();
    rdc(`UHP_OFS_PWR_CS, 32'h0000_8003);
    chk(power_event_out, 32'h0);
    wr(`UHP_OFS_PWR_CS, 32'h0000_0103);
    rdc(`UHP_OFS_PWR_CS, 32'h0000_8103);
    chk(power_event_out, 32'h1);
    wr(`UHP_OFS_PWR_CS, 32'h0000_8100);
    rdc(`UHP_OFS_PWR_CS, 32'h0000_0100);
    chk(power_event_out, 32'h0);
    $display("test power event done");
  endtask
  task automatic t_ext;
    logic [2:0] n [5] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h7};
    logic [4:0] p [5] = '{5'h1F, 5'h0F, 5'h07, 5'h03, 5'h00};
    for (int i = 0; i < 5; i++) begin
      wr(`UHP_OFS_EXT_ONE, 32'h6C10_3308 | n[i]);
      rdc(`UHP_OFS_EXT_ONE, 32'h6C90_3308 | n[i]);
      chk(port_enable_out, p[i]);
      chk(port_power_switch_report_out, 32'h0);
    end
    chk(legacy_io_space_out, 32'h0);
    chk(legacy_direct_out, 32'h1);
    legacy_strap_in = 1'b1;
    #1;
    chk(legacy_io_space_out, 32'h1);
    chk(legacy_direct_out, 32'h0);
    wr(`UHP_OFS_EXT_ONE, 32'h6CB0_3305);
    chk(legacy_io_space_out, 32'h0);
    chk(legacy_direct_out, 32'h1);
    $display("test extension done");
  endtask
  // capability writes need the unlock; sticky bits need d3cold support
  task automatic t_sticky;
    wr(`UHP_OFS_PWR_CS, 32'h0000_0100);
    func_reset();
    rdc(`UHP_OFS_PWR_CS, 32'h0000_0000);
    wr(`UHP_OFS_PMC, 32'hFFC0_0000);
    rdc(`UHP_OFS_PMC, 32'h7E02_0000);
    wr(`UHP_OFS_EXT_ONE, 32'h6CB0_3385);
    chk(subsys_id_write_unlock_out, 32'h1);
    wr(`UHP_OFS_PMC, 32'hFFC0_0000);
    rdc(`UHP_OFS_PMC, 32'hFFC2_0000);
    wr(`UHP_OFS_PWR_CS, 32'h0000_0100);
    resume_pulse();
    func_reset();
    rdc(`UHP_OFS_PWR_CS, 32'h0000_8100);
    rdc(`UHP_OFS_EXT_ONE, 32'h6CB0_3305);
    wr(`UHP_OFS_PWR_CS, 32'h0000_8000);
    rdc(`UHP_OFS_PWR_CS, 32'h0000_0000);
    $display("test sticky done");
  endtask
  // a read during preload is refused, then the loaded image shows
  task automatic t_rom;
    @(negedge clk_in);
    rom_start = 1'b1;
    @(negedge clk_in);
    rom_start = 1'b0;
    cfg_rd_in = 1'b1;
    cfg_addr_in = `UHP_OFS_EXT_ONE;
    #1;
    chk(cfg_retry_out, 32'h1);
    @(negedge clk_in);
    cfg_rd_in = 1'b0;
    chk(cfg_ack_out, 32'h0);
    for (int i = 0; i < 20 && rom_busy !== 1'b0; i++) begin
      @(negedge clk_in);
    end
    rdc(`UHP_OFS_EXT_ONE, 32'h6C90_3303);
    rdc(`UHP_OFS_PMC, 32'hFE02_0000);
    chk(port_enable_out, 32'h07);
    chk(port_power_switch_report_out, 32'h0);
    $display("test rom preload done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    rstn_in = 1'b1;
    auxrstn_in = 1'b1;
    t_reset();
    t_pstate();
    t_event();
    t_ext();
    t_sticky();
    t_rom();
    results();
  end
endmodule
